// *** design/ptw_pkg.sv ***
// package: register map, field positions, reset values and bus types for the periodic timers
package ptw_pkg;

  // ----------------------------------------
  // sizes
  // ----------------------------------------
  localparam int NUM_TIMERS = 9;   // timer 0 is the wake-up timer
  localparam int CNT_W      = 32;
  localparam int ADDR_W     = 12;
  localparam int DATA_W     = 32;

  // ----------------------------------------
  // register byte offsets
  // ----------------------------------------
  localparam logic [ADDR_W-1:0] OFS_RELOAD_BASE = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_RELOAD_LAST = 12'h020;
  localparam logic [ADDR_W-1:0] OFS_COUNT_BASE  = 12'h080;
  localparam logic [ADDR_W-1:0] OFS_COUNT_LAST  = 12'h0a0;
  localparam logic [ADDR_W-1:0] OFS_FLAGS       = 12'h100;
  localparam logic [ADDR_W-1:0] OFS_IRQ_EN      = 12'h104;
  localparam logic [ADDR_W-1:0] OFS_SELECT      = 12'h108;
  localparam logic [ADDR_W-1:0] OFS_RUN         = 12'h10c;
  localparam logic [ADDR_W-1:0] OFS_CTRL        = 12'h110;

  // ----------------------------------------
  // field positions and reset values
  // ----------------------------------------
  localparam int                CTRL_GATE_BIT  = 24;
  localparam int                CTRL_SPARE_BIT = 25;
  localparam logic [DATA_W-1:0] SELECT_RESET   = 32'h0000_0001;
  localparam logic [DATA_W-1:0] CTRL_RESET     = 32'h0100_0000;
  localparam logic [CNT_W-1:0]  RELOAD_RESET   = 32'h0000_0000;

  // ----------------------------------------
  // bus answers
  // ----------------------------------------
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // channel states of the bus slave
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_TAKE = 2'b01,
    BUS_RESP = 2'b10
  } ptw_bus_state_type;

  // one register write as seen by the register file
  typedef struct packed {
    logic              fire;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic [3:0]        strb;
  } ptw_wr_type;

endpackage

// *** design/ptw_timer_top.sv ***
// module: nine periodic down-counting timers with an AXI4-Lite register slave
`timescale 1ns/1ps
module ptw_timer_top
  import ptw_pkg::*;
(
  // clock and reset
  input  wire logic              CLK_IN,
  input  wire logic              RST_B_IN,
  // system side
  input  wire logic              OSC_CLK_IN,
  input  wire logic              DEBUG_IN,
  input  wire logic              HALT_REQ_IN,
  // axi write address
  input  wire logic [ADDR_W-1:0] AWADDR_IN,
  input  wire logic              AWVALID_IN,
  output logic                   AWREADY_OUT,
  // axi write data
  input  wire logic [DATA_W-1:0] WDATA_IN,
  input  wire logic [3:0]        WSTRB_IN,
  input  wire logic              WVALID_IN,
  output logic                   WREADY_OUT,
  // axi write response
  output logic [1:0]             BRESP_OUT,
  output logic                   BVALID_OUT,
  input  wire logic              BREADY_IN,
  // axi read address
  input  wire logic [ADDR_W-1:0] ARADDR_IN,
  input  wire logic              ARVALID_IN,
  output logic                   ARREADY_OUT,
  // axi read data
  output logic [DATA_W-1:0]      RDATA_OUT,
  output logic [1:0]             RRESP_OUT,
  output logic                   RVALID_OUT,
  input  wire logic              RREADY_IN,
  // timer events
  output logic [8:1]             TRIG_OUT,
  output logic [8:1]             CH_IRQ_OUT,
  output logic                   WAKE_IRQ_OUT
);

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  ptw_bus_state_type       wr_state_ff;
  ptw_bus_state_type       rd_state_ff;
  ptw_wr_type              wr_c;
  logic                    awready_ff;
  logic                    wready_ff;
  logic                    bvalid_ff;
  logic [1:0]              bresp_ff;
  logic                    arready_ff;
  logic                    rvalid_ff;
  logic [1:0]              rresp_ff;
  logic [DATA_W-1:0]       rdata_ff;
  logic [DATA_W-1:0]       rd_data_c;
  logic                    rd_err_c;
  logic                    wr_err_c;
  logic [CNT_W-1:0]        reload_ff [NUM_TIMERS];
  logic [CNT_W-1:0]        count_ff  [NUM_TIMERS];
  logic [NUM_TIMERS-1:0]   active_ff;
  logic [NUM_TIMERS-1:0]   flag_ff;
  logic [NUM_TIMERS-1:0]   irq_en_ff;
  logic [8:1]              select_ff;
  logic [NUM_TIMERS-1:0]   run_ff;
  logic                    gate_ff;
  logic                    spare_ff;
  logic [NUM_TIMERS-1:0]   tick_c;
  logic [NUM_TIMERS-1:0]   expire_c;
  logic [NUM_TIMERS-1:0]   flag_clr_c;
  logic [8:1]              trig_ff;
  logic [8:1]              ch_irq_ff;
  logic                    wake_irq_ff;
  logic                    osc_meta_ff;
  logic                    osc_sync_ff;
  logic                    osc_prev_ff;
  logic                    osc_rise_c;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // byte-lane merge of a write into an old value
  function automatic logic [DATA_W-1:0] merge_bytes(input logic [DATA_W-1:0] old_val,
                                                    input logic [DATA_W-1:0] new_val,
                                                    input logic [3:0]        strb);
    logic [DATA_W-1:0] res;
    res = old_val;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = new_val[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // true when an address falls on a register word
  function automatic logic is_mapped(input logic [ADDR_W-1:0] addr);
    logic ok;
    ok = (addr[1:0] == 2'h0) &&
         ((addr <= OFS_RELOAD_LAST) ||
          ((addr >= OFS_COUNT_BASE) && (addr <= OFS_COUNT_LAST)) ||
          ((addr >= OFS_FLAGS) && (addr <= OFS_CTRL)));
    return ok;
  endfunction

  // ----------------------------------------
  // oscillator clock sampling
  // ----------------------------------------
  // two-stage synchroniser, edge taken from the second stage
  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      osc_meta_ff <= 1'b0;
      osc_sync_ff <= 1'b0;
      osc_prev_ff <= 1'b0;
    end else begin
      osc_meta_ff <= OSC_CLK_IN;
      osc_sync_ff <= osc_meta_ff;
      osc_prev_ff <= osc_sync_ff;
    end
  end

  assign osc_rise_c = osc_sync_ff & ~osc_prev_ff;

  // ----------------------------------------
  // write channel
  // ----------------------------------------
  // take address and data together once both are offered
  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      wr_state_ff <= BUS_IDLE;
      awready_ff  <= 1'b0;
      wready_ff   <= 1'b0;
      bvalid_ff   <= 1'b0;
      bresp_ff    <= RESP_OKAY;
    end else begin
      case (wr_state_ff)
        BUS_IDLE: begin
          if (AWVALID_IN && WVALID_IN) begin
            awready_ff  <= 1'b1;
            wready_ff   <= 1'b1;
            wr_state_ff <= BUS_TAKE;
          end
        end
        BUS_TAKE: begin
          awready_ff  <= 1'b0;
          wready_ff   <= 1'b0;
          bvalid_ff   <= 1'b1;
          bresp_ff    <= wr_err_c ? RESP_SLVERR : RESP_OKAY;
          wr_state_ff <= BUS_RESP;
        end
        BUS_RESP: begin
          if (BREADY_IN) begin
            bvalid_ff   <= 1'b0;
            wr_state_ff <= BUS_IDLE;
          end
        end
        default: begin
          wr_state_ff <= BUS_IDLE;
        end
      endcase
    end
  end

  // the write lands in the cycle the handshake completes
  always_comb begin
    wr_c.fire = (wr_state_ff == BUS_TAKE);
    wr_c.addr = AWADDR_IN;
    wr_c.data = WDATA_IN;
    wr_c.strb = WSTRB_IN;
    wr_err_c  = !is_mapped(AWADDR_IN);
  end

  // ----------------------------------------
  // read channel
  // ----------------------------------------
  // one read at a time, data registered with the valid
  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      rd_state_ff <= BUS_IDLE;
      arready_ff  <= 1'b0;
      rvalid_ff   <= 1'b0;
      rresp_ff    <= RESP_OKAY;
      rdata_ff    <= '0;
    end else begin
      case (rd_state_ff)
        BUS_IDLE: begin
          if (ARVALID_IN) begin
            arready_ff  <= 1'b1;
            rd_state_ff <= BUS_TAKE;
          end
        end
        BUS_TAKE: begin
          arready_ff  <= 1'b0;
          rvalid_ff   <= 1'b1;
          rdata_ff    <= rd_data_c;
          rresp_ff    <= rd_err_c ? RESP_SLVERR : RESP_OKAY;
          rd_state_ff <= BUS_RESP;
        end
        BUS_RESP: begin
          if (RREADY_IN) begin
            rvalid_ff   <= 1'b0;
            rd_state_ff <= BUS_IDLE;
          end
        end
        default: begin
          rd_state_ff <= BUS_IDLE;
        end
      endcase
    end
  end

  // read data mux
  always_comb begin
    rd_data_c = '0;
    rd_err_c  = !is_mapped(ARADDR_IN);
    if (ARADDR_IN <= OFS_RELOAD_LAST) begin
      rd_data_c = reload_ff[ARADDR_IN[5:2]];
    end else if ((ARADDR_IN >= OFS_COUNT_BASE) && (ARADDR_IN <= OFS_COUNT_LAST)) begin
      rd_data_c = count_ff[ARADDR_IN[5:2]];
    end else begin
      case (ARADDR_IN)
        OFS_FLAGS:  rd_data_c[NUM_TIMERS-1:0] = flag_ff;
        OFS_IRQ_EN: rd_data_c[NUM_TIMERS-1:0] = irq_en_ff;
        OFS_SELECT: rd_data_c[8:0] = {select_ff, SELECT_RESET[0]};
        OFS_RUN:    rd_data_c[NUM_TIMERS-1:0] = run_ff;
        OFS_CTRL: begin
          rd_data_c[CTRL_GATE_BIT]  = gate_ff;
          rd_data_c[CTRL_SPARE_BIT] = spare_ff;
        end
        default:    rd_data_c = '0;
      endcase
    end
  end

  // ----------------------------------------
  // control registers
  // ----------------------------------------
  // enables, select, run bits and module control
  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      irq_en_ff <= '0;
      select_ff <= SELECT_RESET[8:1];
      run_ff    <= '0;
      gate_ff   <= CTRL_RESET[CTRL_GATE_BIT];
      spare_ff  <= CTRL_RESET[CTRL_SPARE_BIT];
    end else if (wr_c.fire) begin
      case (wr_c.addr)
        OFS_IRQ_EN: irq_en_ff <= {wr_c.strb[1] ? wr_c.data[8] : irq_en_ff[8],
                                  wr_c.strb[0] ? wr_c.data[7:0] : irq_en_ff[7:0]};
        OFS_SELECT: begin
          if (wr_c.strb[0]) select_ff[7:1] <= wr_c.data[7:1];
          if (wr_c.strb[1]) select_ff[8]   <= wr_c.data[8];
        end
        OFS_RUN:    run_ff <= {wr_c.strb[1] ? wr_c.data[8] : run_ff[8],
                               wr_c.strb[0] ? wr_c.data[7:0] : run_ff[7:0]};
        OFS_CTRL: begin
          if (wr_c.strb[3]) begin
            gate_ff  <= wr_c.data[CTRL_GATE_BIT];
            spare_ff <= wr_c.data[CTRL_SPARE_BIT];
          end
        end
        default: begin
          run_ff <= run_ff;
        end
      endcase
    end
  end

  // ----------------------------------------
  // reload values
  // ----------------------------------------
  // a write never touches the running count, only the next reload
  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      for (int i = 0; i < NUM_TIMERS; i++) begin
        reload_ff[i] <= RELOAD_RESET;
      end
    end else if (wr_c.fire && !wr_err_c && (wr_c.addr <= OFS_RELOAD_LAST)) begin
      reload_ff[wr_c.addr[5:2]] <= merge_bytes(reload_ff[wr_c.addr[5:2]],
                                               wr_c.data, wr_c.strb);
    end
  end

  // ----------------------------------------
  // timer ticks
  // ----------------------------------------
  // wake timer on oscillator edges, channels on the gated core clock
  always_comb begin
    tick_c[0]  = run_ff[0] & osc_rise_c & ~DEBUG_IN;
    flag_clr_c = '0;
    for (int i = 1; i < NUM_TIMERS; i++) begin
      tick_c[i] = run_ff[i] & ~gate_ff & ~DEBUG_IN & ~HALT_REQ_IN;
    end
    if (wr_c.fire && (wr_c.addr == OFS_FLAGS) && wr_c.strb[0]) begin
      flag_clr_c[7:0] = wr_c.data[7:0];
    end
    if (wr_c.fire && (wr_c.addr == OFS_FLAGS) && wr_c.strb[1]) begin
      flag_clr_c[8] = wr_c.data[8];
    end
    for (int i = 0; i < NUM_TIMERS; i++) begin
      expire_c[i] = tick_c[i] & active_ff[i] & (count_ff[i] == '0);
    end
  end

  // ----------------------------------------
  // counters
  // ----------------------------------------
  // first tick after start loads, zero reloads, otherwise count down
  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      active_ff <= '0;
      for (int i = 0; i < NUM_TIMERS; i++) begin
        count_ff[i] <= '0;
      end
    end else begin
      for (int i = 0; i < NUM_TIMERS; i++) begin
        if (!run_ff[i]) begin
          active_ff[i] <= 1'b0;
        end else if (tick_c[i]) begin
          active_ff[i] <= 1'b1;
          if (!active_ff[i] || (count_ff[i] == '0)) begin
            count_ff[i] <= reload_ff[i];
          end else begin
            count_ff[i] <= count_ff[i] - 1'b1;
          end
        end
      end
    end
  end

  // ----------------------------------------
  // flags
  // ----------------------------------------
  // timeout sets, write one clears, a set in the same cycle wins
  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      flag_ff <= '0;
    end else begin
      flag_ff <= (flag_ff & ~flag_clr_c) | expire_c;
    end
  end

  // ----------------------------------------
  // triggers and interrupt lines
  // ----------------------------------------
  // trigger only in dma mode; wake timer never triggers
  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      trig_ff     <= '0;
      ch_irq_ff   <= '0;
      wake_irq_ff <= 1'b0;
    end else begin
      trig_ff     <= expire_c[8:1] & ~select_ff;
      ch_irq_ff   <= flag_ff[8:1] & irq_en_ff[8:1] & select_ff;
      wake_irq_ff <= flag_ff[0] & irq_en_ff[0];
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign AWREADY_OUT  = awready_ff;
  assign WREADY_OUT   = wready_ff;
  assign BVALID_OUT   = bvalid_ff;
  assign BRESP_OUT    = bresp_ff;
  assign ARREADY_OUT  = arready_ff;
  assign RVALID_OUT   = rvalid_ff;
  assign RRESP_OUT    = rresp_ff;
  assign RDATA_OUT    = rdata_ff;
  assign TRIG_OUT     = trig_ff;
  assign CH_IRQ_OUT   = ch_irq_ff;
  assign WAKE_IRQ_OUT = wake_irq_ff;

endmodule

// *** verif/ptw_timer_asserts.sv ***
// checker: bus answer and trigger timing properties of the periodic timers
`timescale 1ns/1ps
module ptw_timer_asserts
  import ptw_pkg::*;
(
  // clock and reset
  input wire logic              CLK_IN,
  input wire logic              RST_B_IN,
  // observed ports
  input wire logic              DEBUG_IN,
  input wire logic              HALT_REQ_IN,
  input wire logic              AWREADY_OUT,
  input wire logic              ARREADY_OUT,
  input wire logic [1:0]        BRESP_OUT,
  input wire logic              BVALID_OUT,
  input wire logic              BREADY_IN,
  input wire logic [DATA_W-1:0] RDATA_OUT,
  input wire logic              RVALID_OUT,
  input wire logic              RREADY_IN,
  input wire logic [8:1]        TRIG_OUT
);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (!RST_B_IN);

  trig_one_cycle_a: assert property ((TRIG_OUT & $past(TRIG_OUT)) == 8'h00)
    else $error("trigger pulse longer than one cycle");
  debug_freeze_a: assert property (DEBUG_IN ##1 DEBUG_IN |-> TRIG_OUT == 8'h00)
    else $error("trigger while frozen for debug");
  halt_freeze_a: assert property ($past(HALT_REQ_IN) && HALT_REQ_IN |-> !TRIG_OUT)
    else $error("trigger while stop requested");
  wr_answer_a: assert property (AWREADY_OUT |=> BVALID_OUT && !AWREADY_OUT)
    else $error("write answer late");
  rd_answer_a: assert property (ARREADY_OUT |=> RVALID_OUT && !ARREADY_OUT)
    else $error("read answer late");
  resp_hold_a: assert property (BVALID_OUT && !BREADY_IN |=> BVALID_OUT && $stable(BRESP_OUT))
    else $error("write response dropped");
  rdata_hold_a: assert property (RVALID_OUT && !RREADY_IN |=> RVALID_OUT && $stable(RDATA_OUT))
    else $error("read data dropped");
  resp_release_a: assert property (BVALID_OUT && BREADY_IN |=> !BVALID_OUT)
    else $error("write response repeated");

  // main scenarios
  cover property (TRIG_OUT == 8'hff);
  cover property (DEBUG_IN ##1 DEBUG_IN);
  cover property (RVALID_OUT && !RREADY_IN);
endmodule

// *** verif/ptw_far_model.sv ***
// far side model: oscillator source and trigger-counting dma controller
`timescale 1ns/1ps
module ptw_far_model (
  // clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_b_in,
  // oscillator control and triggers
  input  wire logic       osc_en_in,
  input  wire logic [8:1] trig_in,
  output logic            osc_out,
  output logic [31:0]     pulses_out
);
  // oscillator at 80 ns, unrelated phase, still while disabled
  initial begin
    osc_out = 1'b0;
    #3;
    forever begin
      #40;
      osc_out = osc_en_in ? ~osc_out : 1'b0;
    end
  end

  // dma side takes one request per pulse cycle and channel
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pulses_out <= 32'h0000_0000;
    end else begin
      pulses_out <= pulses_out + 32'($countones(trig_in));
    end
  end
endmodule

// *** verif/ptw_timer_top_bench.sv ***
// bench: register, timer, freeze and wake-up scenarios of the periodic timers
`timescale 1ns/1ps
module ptw_timer_top_bench;
  import ptw_pkg::*;
  logic              clk, rst_b, dbg, halt, osc_en, osc, wake_irq;
  logic              awvalid, awready, wvalid, wready, bvalid, bready;
  logic              arvalid, arready, rvalid, rready;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [DATA_W-1:0] wdata, rdata, rd, v, p, pulses;
  logic [3:0]        wstrb;
  logic [1:0]        bresp, rresp, lresp;
  logic [8:1]        trig, ch_irq;
  int                errors, checked, n_w;

  ptw_timer_top i_ptw_timer_top (.CLK_IN(clk), .RST_B_IN(rst_b), .OSC_CLK_IN(osc),
    .DEBUG_IN(dbg), .HALT_REQ_IN(halt), .AWADDR_IN(awaddr), .AWVALID_IN(awvalid),
    .AWREADY_OUT(awready), .WDATA_IN(wdata), .WSTRB_IN(wstrb), .WVALID_IN(wvalid),
    .WREADY_OUT(wready), .BRESP_OUT(bresp), .BVALID_OUT(bvalid), .BREADY_IN(bready),
    .ARADDR_IN(araddr), .ARVALID_IN(arvalid), .ARREADY_OUT(arready), .RDATA_OUT(rdata),
    .RRESP_OUT(rresp), .RVALID_OUT(rvalid), .RREADY_IN(rready), .TRIG_OUT(trig),
    .CH_IRQ_OUT(ch_irq), .WAKE_IRQ_OUT(wake_irq));
  ptw_far_model i_ptw_far_model (.clk_in(clk), .rst_b_in(rst_b), .osc_en_in(osc_en),
    .trig_in(trig), .osc_out(osc), .pulses_out(pulses));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic complete_run();
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic to();
    errors++;
    $display("ERROR %0t wait bound used up", $time);
    complete_run();
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      errors++;
      $display("ERROR %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask
  // write: response accepted late so the slave must hold it
  task automatic axw(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (n == 3) bready <= 1'b1;
      if (n > 60) to();
    end while (!(bvalid && bready));
    bready <= 1'b0;
    lresp = bresp;
  endtask
  task automatic axr(input logic [ADDR_W-1:0] a);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (arready) arvalid <= 1'b0;
      if (n == 3) rready <= 1'b1;
      if (n > 60) to();
    end while (!(rvalid && rready));
    rready <= 1'b0;
    rd = rdata;
    lresp = rresp;
  endtask
  // cycles until a trigger on any masked channel
  task automatic wt(input logic [8:1] m);
    n_w = 0;
    do begin
      @(posedge clk);
      n_w++;
      if (n_w > 900) to();
    end while ((trig & m) == 8'h00);
  endtask

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    {errors, checked} = '0;
    {dbg, halt, osc_en, awvalid, wvalid, bready, arvalid, rready, rst_b} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hf;
    cyc(2);
    rst_b <= 1'b1;
    cyc(1);
    axr(OFS_CTRL);
    chk(rd, CTRL_RESET);
    axr(OFS_SELECT);
    chk(rd, SELECT_RESET);
    axr(12'h200);
    chk({30'h0, lresp}, {30'h0, RESP_SLVERR});
    axw(12'h200, 32'h0);
    chk({30'h0, lresp}, {30'h0, RESP_SLVERR});
    axw(OFS_CTRL, 32'h0200_0000);
    chk({30'h0, lresp}, {30'h0, RESP_OKAY});
    axr(OFS_CTRL);
    chk(rd, 32'h0200_0000);
    $display("test reset done");
    axw(OFS_CTRL, 32'h0300_0000); // timers 1-8 disabled again
    axr(OFS_CTRL);
    chk(rd, 32'h0300_0000);
    axw(OFS_RELOAD_BASE + 12'h004, 32'h4);
    axw(OFS_SELECT, 32'h0);
    axw(OFS_RUN, 32'h2);
    cyc(20);
    chk(pulses, 32'h0);
    axw(OFS_CTRL, 32'h0200_0000);
    wt(8'h01);
    wt(8'h01);
    chk(n_w, 5);
    axw(OFS_RELOAD_BASE + 12'h004, 32'h9);
    wt(8'h01);
    chk({31'h0, n_w < 6}, 32'h1);
    wt(8'h01);
    chk(n_w, 10);
    axw(OFS_RUN, 32'h0);
    axw(OFS_RELOAD_BASE + 12'h004, 32'h2);
    axw(OFS_RUN, 32'h2);
    wt(8'h01);
    chk({31'h0, n_w < 6}, 32'h1);
    wt(8'h01);
    chk(n_w, 3);
    $display("test period done");
    axw(OFS_RUN, 32'h0);
    axr(OFS_COUNT_BASE + 12'h004);
    v = rd;
    cyc(4);
    axr(OFS_COUNT_BASE + 12'h004);
    chk(rd, v);
    axr(OFS_FLAGS);
    chk(rd, 32'h2);
    axw(OFS_FLAGS, 32'h0);
    axr(OFS_FLAGS);
    chk(rd, 32'h2);
    axw(OFS_FLAGS, 32'h2);
    axr(OFS_FLAGS);
    chk(rd, 32'h0);
    $display("test flags done");
    axw(OFS_SELECT, 32'h2);
    p = pulses;
    axw(OFS_RUN, 32'h2);
    cyc(10);
    axw(OFS_RUN, 32'h0);
    chk(pulses, p);
    chk({24'h0, ch_irq}, 32'h0);
    axw(OFS_IRQ_EN, 32'h2);
    cyc(2);
    chk({24'h0, ch_irq}, 32'h1);
    axw(OFS_FLAGS, 32'h2);
    cyc(2);
    chk({24'h0, ch_irq}, 32'h0);
    axw(OFS_IRQ_EN, 32'h100);
    axr(OFS_IRQ_EN);
    chk(rd, 32'h100);
    $display("test irq done");
    axw(OFS_SELECT, 32'h0);
    for (int i = 1; i < 9; i++) begin
      axw(OFS_RELOAD_BASE + 12'(4 * i), 32'h3);
    end
    axw(OFS_RUN, 32'h1fe);
    wt(8'hff);
    chk({24'h0, trig}, 32'hff);
    $display("test sync start done");
    for (int k = 0; k < 2; k++) begin
      if (k == 1) halt <= 1'b1;
      else dbg <= 1'b1;
      cyc(3);
      p = pulses;
      axr(OFS_COUNT_BASE + 12'h004);
      v = rd;
      axr(OFS_COUNT_BASE + 12'h004);
      chk(rd, v);
      chk(pulses, p);
      dbg <= 1'b0;
      halt <= 1'b0;
      cyc(10);
      chk({31'h0, pulses != p}, 32'h1);
    end
    $display("test freeze done");
    axw(OFS_RUN, 32'h0);
    osc_en <= 1'b1;
    axw(OFS_RELOAD_BASE, 32'h20);
    axw(OFS_IRQ_EN, 32'h1);
    axw(OFS_FLAGS, 32'h1ff);
    axw(OFS_RUN, 32'h1);
    halt <= 1'b1;
    p = pulses;
    n_w = 0;
    while (wake_irq !== 1'b1) begin
      @(posedge clk);
      n_w++;
      if (n_w > 1000) to();
    end
    chk(pulses, p);
    axr(OFS_COUNT_BASE);
    chk({31'h0, rd <= 32'h20}, 32'h1);
    axw(OFS_FLAGS, 32'h1);
    cyc(2);
    chk({31'h0, wake_irq}, 32'h0);
    halt <= 1'b0;
    $display("test wake done");
    complete_run();
  end
endmodule

bind ptw_timer_top ptw_timer_asserts i_ptw_timer_asserts (.CLK_IN(CLK_IN),
  .RST_B_IN(RST_B_IN), .DEBUG_IN(DEBUG_IN), .HALT_REQ_IN(HALT_REQ_IN),
  .AWREADY_OUT(AWREADY_OUT), .ARREADY_OUT(ARREADY_OUT), .BRESP_OUT(BRESP_OUT),
  .BVALID_OUT(BVALID_OUT), .BREADY_IN(BREADY_IN), .RDATA_OUT(RDATA_OUT),
  .RVALID_OUT(RVALID_OUT), .RREADY_IN(RREADY_IN), .TRIG_OUT(TRIG_OUT));
